// ===== rtl/dtm_map.vh
// Register map, field positions and reset values of the dual timer register slice
`ifndef DTM_MAP_VH
`define DTM_MAP_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define DTM_IDX_TMCTL 6'h08
`define DTM_IDX_INTCTL 6'h09
`define DTM_IDX_T1WIN 6'h0A
`define DTM_IDX_T2WIN 6'h0B
`define DTM_IDX_T1PRE 6'h0E
`define DTM_IDX_STAT 6'h20
`define DTM_IDX_MASK 6'h21

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define DTM_B_PWM_SEL 0
`define DTM_B_GIE 1
`define DTM_B_T1_UNMASK 2
`define DTM_B_T2_UNMASK 3
`define DTM_B_T1_RELOAD 0
`define DTM_B_T1_CLKSRC 1
`define DTM_B_T1_RUN 2
`define DTM_B_T2_RUN 3
`define DTM_B_T1_TOGGLE 3
`define DTM_B_T1_FLAG 0
`define DTM_B_T2_FLAG 1

// ----------------------------------------------------------------
// Reset values and bus answers
// ----------------------------------------------------------------
`define DTM_RST_NIB 4'h0
`define DTM_RST_FLAGS 2'h0
`define DTM_RST_BYTE 8'h00
`define DTM_RESP_OKAY 2'h0
`define DTM_RESP_SLVERR 2'h2
`define DTM_T2_DIV_CODE 3'h0

`endif

// ===== rtl/dtm_prescale.v
// Power-of-two clock prescaler: code 0 divides by 256, code 7 by 2
`timescale 1ns/10ps
`default_nettype none

module dtm_prescale #(
  parameter WIDTH = 8
) (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire [2:0] code,
  output wire tick
);

  reg [WIDTH-1:0] cnt_reg;
  wire [WIDTH-1:0] care;
  wire [3:0] span;

  // Number of low counter bits that must all be ones for a tick
  assign span = 4'h8 - {1'b0, code};

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign care[i] = (i >= span) | cnt_reg[i];
    end
  endgenerate

  assign tick = &care;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= {WIDTH{1'b0}};
    end else if (ce) begin
      cnt_reg <= cnt_reg + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule // dtm_prescale

`default_nettype wire

// ===== rtl/dtm_timer.v
// Eight-bit up counter with load, run gate, overflow pulse and optional reload
`timescale 1ns/10ps
`default_nettype none

module dtm_timer (
  input wire clk,
  input wire rst_n,
  input wire ce,
  input wire run,
  input wire tick,
  input wire reload_en,
  input wire [7:0] reload_val,
  input wire load,
  input wire [7:0] load_val,
  output reg [7:0] count,
  output wire ovf
);

  // Overflow is the step out of all ones
  assign ovf = run & tick & (&count) & ~load;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else if (ce) begin
      // A software load beats a count in the same cycle
      if (load) begin
        count <= load_val;
      end else if (ovf) begin
        count <= reload_en ? reload_val : 8'h00;
      end else if (run & tick) begin
        count <= count + 8'h01;
      end
    end
  end

endmodule // dtm_timer

`default_nettype wire

// ===== rtl/dtm_regs.v
// Dual timer interrupt, PWM pin and counter window register slice with AXI4-Lite slave
`timescale 1ns/10ps
`default_nettype none
`include "dtm_map.vh"

// Functional notes
// - Halt clears PWM select, global enable, masks
// - PWM select drives PWM on pin
// - PWM rate follows toggle and reload settings
// - Global enable gates all timer interrupts
// - Timer one mask gates its requests
// - Timer two mask gates its requests
// - Timer one counter through one nibble window
// - Timer two counter through one nibble window
// - Low nibble first, then high nibble
// - Prescaler code divides clock 256 down to 2
// - Toggle select drives toggle when PWM off
// - Toggle and PWM off keep pin general purpose
// - External source counts pin, pin forced input
// - Run bits start and stop each timer
// - Auto-reload bit enables counter reload
// - Overflow flags stay until software clears
module dtm_regs #(
  parameter ADDR_W = 8
) (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire HALT,
  input wire [ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output wire [1:0] S_AXI_BRESP,
  output wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output wire [31:0] S_AXI_RDATA,
  output wire [1:0] S_AXI_RRESP,
  output wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire PA2_IN,
  output wire PA2_OUT,
  output wire PA2_OE,
  input wire GPIO_PA2_OUT,
  input wire GPIO_PA2_OE,
  input wire [7:0] PWM_DUTY,
  output wire TM1_IRQ_REQ,
  output wire TM2_IRQ_REQ,
  output wire IRQ
);

  // ----------------------------------------------------------------
  // Control and status registers
  // ----------------------------------------------------------------
  reg [3:0] intctl_reg;
  reg [3:0] tmctl_reg;
  reg [3:0] t1pre_reg;
  reg [1:0] stat_reg;
  reg [1:0] mask_reg;
  reg [3:0] intctl_next;
  reg [1:0] stat_next;

  wire pwm_pin_select;
  wire global_interrupt_enable;
  wire timer_one_irq_unmask;
  wire timer_two_irq_unmask;
  wire timer_one_auto_reload;
  wire timer_one_clock_source;
  wire timer_one_run;
  wire timer_two_run;
  wire [2:0] timer_one_divider;
  wire timer_one_toggle_pin_select;

  assign pwm_pin_select = intctl_reg[`DTM_B_PWM_SEL];
  assign global_interrupt_enable = intctl_reg[`DTM_B_GIE];
  assign timer_one_irq_unmask = intctl_reg[`DTM_B_T1_UNMASK];
  assign timer_two_irq_unmask = intctl_reg[`DTM_B_T2_UNMASK];
  assign timer_one_auto_reload = tmctl_reg[`DTM_B_T1_RELOAD];
  assign timer_one_clock_source = tmctl_reg[`DTM_B_T1_CLKSRC];
  assign timer_one_run = tmctl_reg[`DTM_B_T1_RUN];
  assign timer_two_run = tmctl_reg[`DTM_B_T2_RUN];
  assign timer_one_divider = t1pre_reg[2:0];
  assign timer_one_toggle_pin_select = t1pre_reg[`DTM_B_T1_TOGGLE];

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  reg bvalid_reg;
  reg [1:0] bresp_reg;
  wire wr_fire;
  wire wr_en;
  wire [5:0] wr_idx;
  wire [3:0] wr_nib;
  reg wr_known;

  // Address and data are taken together; one write in flight at a time
  assign wr_fire = CE & S_AXI_AWVALID & S_AXI_WVALID & ~bvalid_reg;
  assign S_AXI_AWREADY = wr_fire;
  assign S_AXI_WREADY = wr_fire;
  assign S_AXI_BVALID = bvalid_reg;
  assign S_AXI_BRESP = bresp_reg;
  assign wr_idx = S_AXI_AWADDR[7:2];
  assign wr_nib = S_AXI_WDATA[3:0];
  // Only byte lane 0 carries register bits; other lanes are ignored
  assign wr_en = wr_fire & S_AXI_WSTRB[0];

  always @* begin
    case (wr_idx)
      `DTM_IDX_TMCTL: wr_known = 1'b1;
      `DTM_IDX_INTCTL: wr_known = 1'b1;
      `DTM_IDX_T1WIN: wr_known = 1'b1;
      `DTM_IDX_T2WIN: wr_known = 1'b1;
      `DTM_IDX_T1PRE: wr_known = 1'b1;
      `DTM_IDX_STAT: wr_known = 1'b1;
      `DTM_IDX_MASK: wr_known = 1'b1;
      default: wr_known = 1'b0;
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= `DTM_RESP_OKAY;
    end else if (CE) begin
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_known ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
      end else if (S_AXI_BREADY) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  reg rvalid_reg;
  reg [1:0] rresp_reg;
  reg [3:0] rdata_reg;
  reg [3:0] rd_nib;
  reg rd_known;
  wire rd_fire;
  wire [5:0] rd_idx;
  wire [7:0] cnt_all [0:1];
  wire [3:0] shadow_nib [0:1];
  wire [1:0] rd_hi_sel;

  assign rd_fire = CE & S_AXI_ARVALID & ~rvalid_reg;
  assign S_AXI_ARREADY = CE & ~rvalid_reg;
  assign S_AXI_RVALID = rvalid_reg;
  assign S_AXI_RRESP = rresp_reg;
  assign S_AXI_RDATA = {28'h0000000, rdata_reg};
  assign rd_idx = S_AXI_ARADDR[7:2];

  always @* begin
    rd_known = 1'b1;
    case (rd_idx)
      `DTM_IDX_TMCTL: rd_nib = tmctl_reg;
      `DTM_IDX_INTCTL: rd_nib = intctl_reg;
      // Low read returns live bits, high read the nibble frozen with it
      `DTM_IDX_T1WIN: rd_nib = rd_hi_sel[0] ? shadow_nib[0] : cnt_all[0][3:0];
      `DTM_IDX_T2WIN: rd_nib = rd_hi_sel[1] ? shadow_nib[1] : cnt_all[1][3:0];
      `DTM_IDX_T1PRE: rd_nib = t1pre_reg;
      `DTM_IDX_STAT: rd_nib = {2'h0, stat_reg};
      `DTM_IDX_MASK: rd_nib = {2'h0, mask_reg};
      default: begin
        rd_nib = 4'h0;
        rd_known = 1'b0;
      end
    endcase
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= `DTM_RESP_OKAY;
      rdata_reg <= `DTM_RST_NIB;
    end else if (CE) begin
      if (rd_fire) begin
        rvalid_reg <= 1'b1;
        rresp_reg <= rd_known ? `DTM_RESP_OKAY : `DTM_RESP_SLVERR;
        rdata_reg <= rd_nib;
      end else if (S_AXI_RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pin input synchroniser and external clock edge
  // ----------------------------------------------------------------
  reg pa2_meta_reg;
  reg pa2_sync_reg;
  reg pa2_last_reg;
  wire ext_tick;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pa2_meta_reg <= 1'b0;
      pa2_sync_reg <= 1'b0;
      pa2_last_reg <= 1'b0;
    end else if (CE) begin
      pa2_meta_reg <= PA2_IN;
      pa2_sync_reg <= pa2_meta_reg;
      pa2_last_reg <= pa2_sync_reg;
    end
  end

  assign ext_tick = pa2_sync_reg & ~pa2_last_reg;

  // ----------------------------------------------------------------
  // Prescalers and tick selection
  // ----------------------------------------------------------------
  wire t1_int_tick;
  wire t2_int_tick;
  wire [1:0] tick_all;
  wire [1:0] run_all;
  wire [1:0] reload_all;
  wire [1:0] ovf_all;

  dtm_prescale #(
    .WIDTH(8)
  ) u_pre1 (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .code(timer_one_divider),
    .tick(t1_int_tick)
  );

  // Timer two runs from a fixed division by 256; its prescaler code is not programmable
  dtm_prescale #(
    .WIDTH(8)
  ) u_pre2 (
    .clk(CLK),
    .rst_n(RST_N),
    .ce(CE),
    .code(`DTM_T2_DIV_CODE),
    .tick(t2_int_tick)
  );

  assign tick_all[0] = timer_one_clock_source ? ext_tick : t1_int_tick;
  assign tick_all[1] = t2_int_tick;
  assign run_all = {timer_two_run, timer_one_run};
  // Timer two always reloads its last written value
  assign reload_all = {1'b1, timer_one_auto_reload};

  // ----------------------------------------------------------------
  // Counter windows and timers, one per channel
  // ----------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_tmr
      localparam [5:0] WIN_IDX = (g == 0) ? `DTM_IDX_T1WIN : `DTM_IDX_T2WIN;
      reg wr_hi_reg;
      reg [3:0] lo_pend_reg;
      reg [7:0] reload_reg;
      reg rd_hi_reg;
      reg [3:0] shadow_reg;
      wire win_wr;
      wire win_rd;
      wire load;

      assign win_wr = wr_en & (wr_idx == WIN_IDX);
      assign win_rd = rd_fire & (rd_idx == WIN_IDX);
      assign load = win_wr & wr_hi_reg;
      assign rd_hi_sel[g] = rd_hi_reg;
      assign shadow_nib[g] = shadow_reg;

      always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
          wr_hi_reg <= 1'b0;
          lo_pend_reg <= `DTM_RST_NIB;
          reload_reg <= `DTM_RST_BYTE;
          rd_hi_reg <= 1'b0;
          shadow_reg <= `DTM_RST_NIB;
        end else if (CE) begin
          // Write pair: low nibble parks, high nibble commits the byte
          if (win_wr) begin
            wr_hi_reg <= ~wr_hi_reg;
            if (!wr_hi_reg) begin
              lo_pend_reg <= wr_nib;
            end else begin
              reload_reg <= {wr_nib, lo_pend_reg};
            end
          end
          // Read pair: low read freezes the upper nibble for the next read
          if (win_rd) begin
            rd_hi_reg <= ~rd_hi_reg;
            if (!rd_hi_reg) begin
              shadow_reg <= cnt_all[g][7:4];
            end
          end
        end
      end

      dtm_timer u_tmr (
        .clk(CLK),
        .rst_n(RST_N),
        .ce(CE),
        .run(run_all[g]),
        .tick(tick_all[g]),
        .reload_en(reload_all[g]),
        .reload_val(reload_reg),
        .load(load),
        .load_val({wr_nib, lo_pend_reg}),
        .count(cnt_all[g]),
        .ovf(ovf_all[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Register writes, halt clear and sticky flags
  // ----------------------------------------------------------------
  always @* begin
    intctl_next = intctl_reg;
    if (wr_en && wr_idx == `DTM_IDX_INTCTL) begin
      intctl_next = wr_nib;
    end
    // Halt wins over a write in the same cycle
    if (HALT) begin
      intctl_next = 4'h0;
    end
    stat_next = stat_reg;
    if (wr_en && wr_idx == `DTM_IDX_STAT) begin
      stat_next = stat_reg & ~wr_nib[1:0];
    end
    // A new overflow beats a clear arriving in the same cycle
    stat_next = stat_next | ovf_all;
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      intctl_reg <= `DTM_RST_NIB;
      tmctl_reg <= `DTM_RST_NIB;
      t1pre_reg <= `DTM_RST_NIB;
      stat_reg <= `DTM_RST_FLAGS;
      mask_reg <= `DTM_RST_FLAGS;
    end else if (CE) begin
      intctl_reg <= intctl_next;
      stat_reg <= stat_next;
      if (wr_en && wr_idx == `DTM_IDX_TMCTL) begin
        tmctl_reg <= wr_nib;
      end
      if (wr_en && wr_idx == `DTM_IDX_T1PRE) begin
        t1pre_reg <= wr_nib;
      end
      if (wr_en && wr_idx == `DTM_IDX_MASK) begin
        mask_reg <= wr_nib[1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt requests
  // ----------------------------------------------------------------
  assign TM1_IRQ_REQ = stat_reg[`DTM_B_T1_FLAG] & timer_one_irq_unmask
                     & global_interrupt_enable;
  assign TM2_IRQ_REQ = stat_reg[`DTM_B_T2_FLAG] & timer_two_irq_unmask
                     & global_interrupt_enable;
  assign IRQ = (TM1_IRQ_REQ & mask_reg[`DTM_B_T1_FLAG])
             | (TM2_IRQ_REQ & mask_reg[`DTM_B_T2_FLAG]);

  // ----------------------------------------------------------------
  // Toggle, PWM and pin mux
  // ----------------------------------------------------------------
  reg toggle_reg;
  reg pin_out_reg;
  reg pin_oe_reg;
  reg pin_out_next;
  reg pin_oe_next;
  wire toggle_active;
  wire pwm_level;

  // Toggle runs for the toggle pin and as the PWM rate divider
  assign toggle_active = timer_one_toggle_pin_select;

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      toggle_reg <= 1'b0;
    end else if (CE) begin
      if (toggle_active && ovf_all[0]) begin
        toggle_reg <= ~toggle_reg;
      end
    end
  end

  // Period is the timer one overflow rate, set by the reload value;
  // toggle select doubles it into a square wave
  assign pwm_level = timer_one_toggle_pin_select ? toggle_reg
                   : (cnt_all[0] < PWM_DUTY);

  always @* begin
    pin_out_next = GPIO_PA2_OUT;
    pin_oe_next = GPIO_PA2_OE;
    if (pwm_pin_select) begin
      pin_out_next = pwm_level;
      pin_oe_next = 1'b1;
    end else if (timer_one_toggle_pin_select) begin
      pin_out_next = toggle_reg;
      pin_oe_next = 1'b1;
    end
    // External clock source needs the pin as an input whatever else asks
    if (timer_one_clock_source) begin
      pin_oe_next = 1'b0;
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_out_reg <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else if (CE) begin
      pin_out_reg <= pin_out_next;
      pin_oe_reg <= pin_oe_next;
    end
  end

  assign PA2_OUT = pin_out_reg;
  assign PA2_OE = pin_oe_reg;

endmodule // dtm_regs

`default_nettype wire

// ===== tb/dtm_regs_asserts.sv
// Port-level concurrent checks for the dual timer register slice
`timescale 1ns/10ps
`default_nettype none

module dtm_regs_asserts (
  input wire CLK,
  input wire RST_N,
  input wire CE,
  input wire HALT,
  input wire S_AXI_AWREADY,
  input wire [1:0] S_AXI_BRESP,
  input wire S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire [31:0] S_AXI_RDATA,
  input wire S_AXI_RVALID,
  input wire S_AXI_RREADY,
  input wire TM1_IRQ_REQ,
  input wire TM2_IRQ_REQ,
  input wire IRQ
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  halt_drops_req_a: assert property (
    HALT && CE |=> !TM1_IRQ_REQ && !TM2_IRQ_REQ && !IRQ)
    else $error("interrupt request survived halt");
  irq_has_source_a: assert property (
    IRQ |-> TM1_IRQ_REQ || TM2_IRQ_REQ)
    else $error("interrupt line without a request");
  t1_flag_sticky_a: assert property (
    TM1_IRQ_REQ && !HALT && !S_AXI_AWREADY |=> TM1_IRQ_REQ)
    else $error("timer one request dropped without a write");
  t2_flag_sticky_a: assert property (
    TM2_IRQ_REQ && !HALT && !S_AXI_AWREADY |=> TM2_IRQ_REQ)
    else $error("timer two request dropped without a write");
  nibble_rdata_a: assert property (
    S_AXI_RVALID |-> S_AXI_RDATA[31:4] == 28'h0)
    else $error("read data above the nibble");
  write_answer_a: assert property (S_AXI_AWREADY |=> S_AXI_BVALID)
    else $error("write taken without response");
  bresp_hold_a: assert property (
    S_AXI_BVALID && !(S_AXI_BREADY && CE) |=> S_AXI_BVALID && $stable(S_AXI_BRESP))
    else $error("write response not held");
  read_answer_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read taken without answer");
  rdata_hold_a: assert property (
    S_AXI_RVALID && !(S_AXI_RREADY && CE) |=> S_AXI_RVALID && $stable(S_AXI_RDATA))
    else $error("read answer not held");
endmodule // dtm_regs_asserts

bind dtm_regs dtm_regs_asserts u_chk (.CLK(CLK), .RST_N(RST_N), .CE(CE), .HALT(HALT),
  .S_AXI_AWREADY(S_AXI_AWREADY), .S_AXI_BRESP(S_AXI_BRESP), .S_AXI_BVALID(S_AXI_BVALID),
  .S_AXI_BREADY(S_AXI_BREADY), .S_AXI_ARVALID(S_AXI_ARVALID), .S_AXI_ARREADY(S_AXI_ARREADY),
  .S_AXI_RDATA(S_AXI_RDATA), .S_AXI_RVALID(S_AXI_RVALID), .S_AXI_RREADY(S_AXI_RREADY),
  .TM1_IRQ_REQ(TM1_IRQ_REQ), .TM2_IRQ_REQ(TM2_IRQ_REQ), .IRQ(IRQ));

`default_nettype wire

// ===== tb/dtm_regs_tb.sv
// Self-checking bench for the dual timer register slice
`timescale 1ns/10ps
`default_nettype none
`include "dtm_map.vh"

module dtm_regs_tb;
  localparam logic [7:0] A_CTL = {`DTM_IDX_TMCTL, 2'b00};
  localparam logic [7:0] A_IC = {`DTM_IDX_INTCTL, 2'b00};
  localparam logic [7:0] A_T1 = {`DTM_IDX_T1WIN, 2'b00};
  localparam logic [7:0] A_T2 = {`DTM_IDX_T2WIN, 2'b00};
  localparam logic [7:0] A_PRE = {`DTM_IDX_T1PRE, 2'b00};
  localparam logic [7:0] A_ST = {`DTM_IDX_STAT, 2'b00};
  localparam logic [7:0] A_MSK = {`DTM_IDX_MASK, 2'b00};
  localparam logic [1:0] OK = `DTM_RESP_OKAY;
  localparam logic [1:0] ERR = `DTM_RESP_SLVERR;
  logic clk = 1'b0;
  logic rst_n, ce, halt, awvalid, wvalid, arvalid, pa2_in, gpio_out, gpio_oe;
  logic [7:0] awaddr, araddr, pwm_duty;
  logic [31:0] wdata;
  wire [31:0] rdata;
  wire [1:0] bresp, rresp;
  wire awready, wready, bvalid, arready, rvalid, pa2_out, pa2_oe, tm1_req, tm2_req, irq;
  int failures = 0;
  int n_tests = 0;

  dtm_regs uut (.CLK(clk), .RST_N(rst_n), .CE(ce), .HALT(halt),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(1'b1),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(1'b1),
    .PA2_IN(pa2_in), .PA2_OUT(pa2_out), .PA2_OE(pa2_oe), .GPIO_PA2_OUT(gpio_out),
    .GPIO_PA2_OE(gpio_oe), .PWM_DUTY(pwm_duty), .TM1_IRQ_REQ(tm1_req),
    .TM2_IRQ_REQ(tm2_req), .IRQ(irq));

  initial forever #12.5 clk = ~clk;

  // ------
  // Bus and compare helpers
  // ------
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic tmo(input logic hit);
    if (hit) begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      print_verdict;
    end
  endtask

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic step(inout int n);
    @(posedge clk);
    n++;
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask

  // Ready and valid are judged at the falling edge, the level the next rising edge sees
  task automatic wr(input logic [7:0] a, input logic [3:0] d, input logic [1:0] r);
    int n;
    logic h;
    logic [1:0] b;
    n = 0;
    b = 2'h3;
    awaddr <= a;
    wdata <= {28'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge clk);
      h = awready;
      step(n);
    end while (h !== 1'b1 && n < 100);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    do begin
      @(negedge clk);
      h = bvalid;
      b = bresp;
      step(n);
    end while (h !== 1'b1 && n < 100);
    tmo(n >= 100);
    chk(32'(b), 32'(r));
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic h;
    n = 0;
    d = 32'hFFFFFFFF;
    r = 2'h3;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge clk);
      h = arready;
      step(n);
    end while (h !== 1'b1 && n < 100);
    arvalid <= 1'b0;
    do begin
      @(negedge clk);
      h = rvalid;
      d = rdata;
      r = rresp;
      step(n);
    end while (h !== 1'b1 && n < 100);
    tmo(n >= 100);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
    chk(32'(r), 32'(er));
  endtask

  // Cycles until the pin level changes; the edge of a code change is not trusted
  task automatic gap(output int g);
    logic v;
    g = 0;
    v = pa2_out;
    do step(g); while (pa2_out === v && g < 600);
    tmo(g >= 600);
  endtask

  // ------
  // Scenarios
  // ------
  task automatic t_reset;
    logic [7:0] tbl [8] = '{A_CTL, A_IC, A_T1, A_T1, A_T2, A_T2, A_PRE, A_MSK};
    foreach (tbl[i]) rdc(tbl[i], 32'h0, OK);
    rdc(A_ST, 32'h0, OK);
    rdc(8'h3C, 32'h0, ERR);
    wr(8'h3C, 4'hF, ERR);
  endtask

  task automatic t_window;
    wr(A_T1, 4'h5, OK);
    rdc(A_T1, 32'h0, OK);
    rdc(A_T1, 32'h0, OK);
    wr(A_T1, 4'hA, OK);
    rdc(A_T1, 32'h5, OK);
    rdc(A_T1, 32'hA, OK);
    wr(A_T2, 4'h3, OK);
    wr(A_T2, 4'hC, OK);
    rdc(A_T2, 32'h3, OK);
    rdc(A_T2, 32'hC, OK);
  endtask

  task automatic t_irq;
    logic [31:0] d;
    logic [1:0] r;
    int n;
    n = 0;
    wr(A_T1, 4'hE, OK);
    wr(A_T1, 4'hF, OK);
    wr(A_PRE, 4'h7, OK);
    wr(A_CTL, 4'h4, OK);
    do begin
      rd(A_ST, d, r);
      n++;
    end while (d[0] !== 1'b1 && n < 20);
    tmo(n >= 20);
    wr(A_CTL, 4'h0, OK);
    chk(32'(tm1_req), 32'h0);
    wr(A_IC, 4'h2, OK);
    chk(32'(tm1_req), 32'h0);
    wr(A_IC, 4'h6, OK);
    chk(32'(tm1_req), 32'h1);
    chk(32'(irq), 32'h0);
    wr(A_MSK, 4'h1, OK);
    chk(32'(irq), 32'h1);
    halt <= 1'b1;
    cyc(1);
    halt <= 1'b0;
    cyc(1);
    chk(32'(tm1_req), 32'h0);
    rdc(A_IC, 32'h0, OK);
    wr(A_IC, 4'h6, OK);
    chk(32'(tm1_req), 32'h1);
    wr(A_ST, 4'h1, OK);
    chk(32'(tm1_req), 32'h0);
    rdc(A_ST, 32'h0, OK);
  endtask

  task automatic t_t2;
    int n;
    n = 0;
    wr(A_IC, 4'hA, OK);
    wr(A_T2, 4'hF, OK);
    wr(A_T2, 4'hF, OK);
    chk(32'(tm2_req), 32'h0);
    wr(A_CTL, 4'h8, OK);
    do step(n); while (tm2_req !== 1'b1 && n < 700);
    tmo(n >= 700);
    chk(32'(tm1_req), 32'h0);
    wr(A_IC, 4'h2, OK);
    chk(32'(tm2_req), 32'h0);
    wr(A_CTL, 4'h0, OK);
    wr(A_ST, 4'h2, OK);
  endtask

  // Reload value FF makes every prescaler tick an overflow and a pin flip
  task automatic t_scale;
    int g;
    wr(A_T1, 4'hF, OK);
    wr(A_T1, 4'hF, OK);
    wr(A_CTL, 4'h5, OK);
    for (int c = 0; c < 8; c++) begin
      wr(A_PRE, 4'h8 | 4'(c), OK);
      gap(g);
      gap(g);
      chk(32'(g), 32'(256 >> c));
      chk(32'(pa2_oe), 32'h1);
    end
    wr(A_CTL, 4'h4, OK);
    gap(g);
    gap(g);
    chk(32'(g), 32'd512);
  endtask

  task automatic t_pin;
    wr(A_CTL, 4'h0, OK);
    wr(A_PRE, 4'h0, OK);
    gpio_out <= 1'b1;
    gpio_oe <= 1'b1;
    cyc(2);
    chk(32'({pa2_out, pa2_oe}), 32'h3);
    wr(A_T1, 4'h0, OK);
    wr(A_T1, 4'h1, OK);
    pwm_duty <= 8'h05;
    wr(A_IC, 4'h1, OK);
    cyc(2);
    chk(32'({pa2_out, pa2_oe}), 32'h1);
    pwm_duty <= 8'h20;
    cyc(2);
    chk(32'({pa2_out, pa2_oe}), 32'h3);
    wr(A_IC, 4'h0, OK);
    wr(A_CTL, 4'h6, OK);
    cyc(2);
    chk(32'(pa2_oe), 32'h0);
    repeat (3) begin
      pa2_in <= 1'b1;
      cyc(4);
      pa2_in <= 1'b0;
      cyc(4);
    end
    cyc(6);
    rdc(A_T1, 32'h3, OK);
    rdc(A_T1, 32'h1, OK);
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    halt = 1'b0;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pa2_in = 1'b0;
    gpio_out = 1'b0;
    gpio_oe = 1'b0;
    pwm_duty = 8'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset;
    t_window;
    t_irq;
    t_t2;
    t_scale;
    t_pin;
    print_verdict;
  end
endmodule // dtm_regs_tb

`default_nettype wire
